//--- osc_ctrl_map.svh
// register offsets, field positions, reset values and unlock keys of the
// oscillator control block; included by its bare name
`ifndef OSC_CTRL_MAP_SVH
`define OSC_CTRL_MAP_SVH

// register indices on the plain register port
`define OSC_IDX_CTRL      3'h0
`define OSC_IDX_DIV       3'h1
`define OSC_IDX_FBD       3'h2
`define OSC_IDX_TUN       3'h3
`define OSC_IDX_UNLOCK    3'h4

// oscillator_control fields
`define OSC_CUR_LSB       12
`define OSC_NEW_LSB       8
`define OSC_FREEZE_BIT    7
`define OSC_PINMAP_BIT    6
`define OSC_PLLLOCK_BIT   5
`define OSC_FAIL_BIT      3
`define OSC_SECEN_BIT     1
`define OSC_SWREQ_BIT     0

// clock_divisor fields
`define DIV_ROI_BIT       15
`define DIV_DOZE_LSB      12
`define DIV_SLOWDOWN_ENABLE_BIT     11
`define DIV_FRC_LSB       8
`define DIV_POST_LSB      6
`define DIV_PRE_LSB       0

// reset values
`define DIV_RESET         16'h3040
`define FBD_RESET         9'h030
`define TUN_RESET         6'h00
`define DOZE_RESET        3'h3
`define POST_RESET        2'h1

// codes
`define SRC_FRC_PLL       3'h1
`define SRC_PRI_PLL       3'h3
`define POST_RESERVED     2'h2
`define MODE_SW_ONLY      2'h1
`define MODE_BOTH_ON      2'h0

// unlock key pair written to the unlock index
`define UNLOCK_KEY1       16'h00AA
`define UNLOCK_KEY2       16'h0055

`endif

//--- osc_ctrl_pkg.sv
// types shared by the oscillator control block
// assumes the map header supplies all numeric constants
package osc_ctrl_pkg;

  typedef struct packed {
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  typedef struct packed {
    logic [2:0] target;
    logic       req;
  } switch_cmd_s;

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_BUSY,
    SW_BOOT
  } switch_state_e;

endpackage : osc_ctrl_pkg

//--- osc_ctrl_regs.sv
// run-time register block of the oscillator system
// assumes rst is the power-on reset only; straps stable around its release;
// clock mux answers a switch command with a one-cycle done pulse
//
// Overview of operation
// - only power-on reset restores register contents
// - read-only current source field, eight codes
// - source fields loaded from nonvolatile straps
// - request bit starts switch, cleared when done
// - freeze bit blocks switching in mode 01
// - pin map freeze rejects pin-select writes
// - lock bit: PLL locked and enabled
// - fail flag sticky until software clears
// - control writes need unlock sequence first
// - secondary enable bit drives secondary oscillator
// - interrupt clears slowdown enable when recovering
// - slowdown field selects power-of-two divide
// - slowdown disabled forces ratio one to one
// - fast RC postscaler divides 1 to 256
// - PLL output divider 2, 4, 8; 10 reserved
// - PLL prescaler divides by code plus two
// - PLL multiplier code plus two, reset 50
// - six-bit fast RC trim in tuning register
// - unimplemented bits read zero, writes ignored
// - mode 00 both, 01 switching, 1x none
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "osc_ctrl_map.svh"

module osc_ctrl_regs #(
  parameter int unsigned SRC_W  = 3,
  parameter int unsigned FBD_W  = 9,
  parameter int unsigned TUN_W  = 6
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire osc_ctrl_pkg::reg_req_s    bus_req,
  output logic [15:0]                    rdata,
  input  wire logic [SRC_W-1:0]          initial_source_setting,
  input  wire logic [1:0]                switching_mode_setting,
  output osc_ctrl_pkg::switch_cmd_s      switch_cmd,
  input  wire logic                      switch_done,
  input  wire logic                      pll_lock_in,
  input  wire logic                      clock_fail_detect,
  input  wire logic                      irq_event,
  input  wire logic                      pin_select_wr_req,
  output logic                           pin_select_wr_accept,
  output logic                           secondary_osc_en,
  output logic [SRC_W-1:0]               current_source,
  output logic [7:0]                     doze_divide,
  output logic [8:0]                     fast_rc_divide,
  output logic [3:0]                     pll_post_divide,
  output logic [5:0]                     pll_pre_divide,
  output logic [9:0]                     pll_multiplier,
  output logic [TUN_W-1:0]               fast_rc_trim
);

  // 2**code, used by both the slowdown and postscaler decode
  function automatic logic [8:0] pow2(input logic [2:0] code);
    pow2 = 9'h001 << code;
  endfunction : pow2

  osc_ctrl_pkg::switch_state_e state_q, state_d;
  logic [SRC_W-1:0] cur_q, new_q;
  logic             freeze_q, pinmap_q, fail_q, secen_q, swreq_q;
  logic             roi_q, slowdown_enable_q;
  logic [2:0]       doze_q, fast_rc_postscale_q;
  logic [1:0]       post_q;
  logic [4:0]       pre_q;
  logic [FBD_W-1:0] fbd_q;
  logic [TUN_W-1:0] tun_q;
  logic             key1_q, unlocked_q;
  logic [15:0]      rdata_q;

  // register port decode
  wire wr_ctrl   = bus_req.wr && bus_req.addr == `OSC_IDX_CTRL;
  wire wr_div    = bus_req.wr && bus_req.addr == `OSC_IDX_DIV;
  wire wr_fbd    = bus_req.wr && bus_req.addr == `OSC_IDX_FBD;
  wire wr_tun    = bus_req.wr && bus_req.addr == `OSC_IDX_TUN;
  wire wr_unlock = bus_req.wr && bus_req.addr == `OSC_IDX_UNLOCK;
  wire [15:0] wd = bus_req.wdata;

  wire ctrl_ok   = wr_ctrl && unlocked_q;

  wire sw_allowed  = !switching_mode_setting[1];
  wire monitor_on  = switching_mode_setting == `MODE_BOTH_ON;
  // freeze blocks only in switching-only mode
  wire frozen      = freeze_q && switching_mode_setting == `MODE_SW_ONLY;
  // a new request is taken only when switching may proceed
  wire req_take    = ctrl_ok && wd[`OSC_SWREQ_BIT] && state_q == osc_ctrl_pkg::SW_IDLE
                     && sw_allowed && !frozen;
  wire post_wr_ok  = wd[`DIV_POST_LSB +: 2] != `POST_RESERVED;

  // lock status only with a PLL source selected
  wire pll_in_use  = cur_q == `SRC_FRC_PLL || cur_q == `SRC_PRI_PLL;
  wire lock_status = pll_lock_in && pll_in_use;

  // read images; unimplemented positions are zero
  wire [15:0] ctrl_img = {1'b0, cur_q, 1'b0, new_q, freeze_q, pinmap_q, lock_status, 1'b0,
                          fail_q, 1'b0, secen_q, swreq_q};
  wire [15:0] div_img  = {roi_q, doze_q, slowdown_enable_q, fast_rc_postscale_q, post_q, 1'b0, pre_q};
  wire [15:0] fbd_img  = {{(16-FBD_W){1'b0}}, fbd_q};
  wire [15:0] tun_img  = {{(16-TUN_W){1'b0}}, tun_q};
  wire [15:0] rd_mux   = bus_req.addr == `OSC_IDX_CTRL ? ctrl_img :
                         bus_req.addr == `OSC_IDX_DIV  ? div_img  :
                         bus_req.addr == `OSC_IDX_FBD  ? fbd_img  :
                         bus_req.addr == `OSC_IDX_TUN  ? tun_img  : 16'h0000;

  // switch sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      osc_ctrl_pkg::SW_BOOT: state_d = osc_ctrl_pkg::SW_IDLE;
      osc_ctrl_pkg::SW_IDLE: if (req_take) state_d = osc_ctrl_pkg::SW_BUSY;
      osc_ctrl_pkg::SW_BUSY: if (switch_done) state_d = osc_ctrl_pkg::SW_IDLE;
      default: state_d = osc_ctrl_pkg::SW_IDLE;
    endcase
  end

  // sequencer state set to boot by power-on reset only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= osc_ctrl_pkg::SW_BOOT;
    end else begin
      state_q <= state_d;
    end
  end

  // source fields: straps at boot, then control writes and switch completion
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_q   <= '0;
      new_q   <= '0;
      swreq_q <= 1'b0;
    end else if (state_q == osc_ctrl_pkg::SW_BOOT) begin
      cur_q   <= initial_source_setting;
      new_q   <= initial_source_setting;
    end else if (state_q == osc_ctrl_pkg::SW_BUSY) begin
      if (switch_done) begin
        cur_q   <= new_q;
        swreq_q <= 1'b0;
      end
    end else if (ctrl_ok) begin
      new_q   <= wd[`OSC_NEW_LSB +: SRC_W];
      swreq_q <= req_take;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      freeze_q <= 1'b0;
      pinmap_q <= 1'b0;
      secen_q  <= 1'b0;
    end else if (ctrl_ok) begin
      freeze_q <= wd[`OSC_FREEZE_BIT];
      pinmap_q <= wd[`OSC_PINMAP_BIT];
      secen_q  <= wd[`OSC_SECEN_BIT];
    end
  end

  // sticky fail flag; a new failure wins over a software clear
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fail_q <= 1'b0;
    end else if (clock_fail_detect && monitor_on) begin
      fail_q <= 1'b1;
    end else if (ctrl_ok && !wd[`OSC_FAIL_BIT]) begin
      fail_q <= 1'b0;
    end
  end

  // unlock: key1 then key2 back to back; consumed by the next write
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      key1_q     <= 1'b0;
      unlocked_q <= 1'b0;
    end else if (bus_req.wr) begin
      key1_q     <= wr_unlock && wd == `UNLOCK_KEY1;
      unlocked_q <= wr_unlock && wd == `UNLOCK_KEY2 && key1_q;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      roi_q    <= 1'b0;
      doze_q   <= `DOZE_RESET;
      slowdown_enable_q  <= 1'b0;
      fast_rc_postscale_q <= 3'h0;
      post_q   <= `POST_RESET;
      pre_q    <= 5'h00;
    end else begin
      if (wr_div) begin
        roi_q    <= wd[`DIV_ROI_BIT];
        doze_q   <= wd[`DIV_DOZE_LSB +: 3];
        fast_rc_postscale_q <= wd[`DIV_FRC_LSB +: 3];
        pre_q    <= wd[`DIV_PRE_LSB +: 5];
        if (post_wr_ok) begin
          post_q <= wd[`DIV_POST_LSB +: 2];
        end
      end
      // interrupt recovery wins over a same-cycle write
      if (irq_event && (wr_div ? wd[`DIV_ROI_BIT] : roi_q)) begin
        slowdown_enable_q <= 1'b0;
      end else if (wr_div) begin
        slowdown_enable_q <= wd[`DIV_SLOWDOWN_ENABLE_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fbd_q <= `FBD_RESET;
      tun_q <= `TUN_RESET;
    end else begin
      if (wr_fbd) fbd_q <= wd[FBD_W-1:0];
      if (wr_tun) tun_q <= wd[TUN_W-1:0];
    end
  end

  // read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= bus_req.rd ? rd_mux : 16'h0000;
    end
  end

  assign rdata = rdata_q;

  // command to the clock mux while a switch is pending
  assign switch_cmd = '{target: new_q, req: state_q == osc_ctrl_pkg::SW_BUSY};
  assign pin_select_wr_accept = pin_select_wr_req && !pinmap_q;
  assign secondary_osc_en = secen_q;
  assign current_source   = cur_q;
  // slowdown ratio, forced to one when disabled
  wire [8:0] doze_pow    = pow2(doze_q);
  assign doze_divide     = slowdown_enable_q ? doze_pow[7:0] : 8'h01;
  assign fast_rc_divide  = fast_rc_postscale_q == 3'h7 ? 9'h100 : pow2(fast_rc_postscale_q);
  assign pll_post_divide = post_q == 2'h3 ? 4'h8 : (post_q == 2'h1 ? 4'h4 : 4'h2);
  assign pll_pre_divide  = {1'b0, pre_q} + 6'h02;
  assign pll_multiplier  = {1'b0, fbd_q} + 10'h002;
  assign fast_rc_trim    = tun_q;

  // ---------------- assertions ----------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_unlock;
    wr_unlock && wd == `UNLOCK_KEY1 ##1 wr_unlock && wd == `UNLOCK_KEY2;
  endsequence

  property p_unlock_write;
    s_unlock ##1 (wr_ctrl && state_q == osc_ctrl_pkg::SW_IDLE) |=>
      new_q == $past(wd[`OSC_NEW_LSB +: SRC_W]);
  endproperty
  a_unlock_write: assert property (p_unlock_write) else $error("unlocked write lost");

  property p_locked_write;
    (wr_ctrl && !unlocked_q && state_q == osc_ctrl_pkg::SW_IDLE) |=> $stable(new_q) && $stable(secen_q);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("locked write took effect");

  property p_boot_straps;
    state_q == osc_ctrl_pkg::SW_BOOT |=> cur_q == $past(initial_source_setting);
  endproperty
  a_boot_straps: assert property (p_boot_straps) else $error("source not loaded from straps");

  sequence s_switch_end;
    switch_cmd.req && switch_done;
  endsequence

  property p_switch_done;
    s_switch_end |=> !swreq_q && cur_q == $past(new_q) && !switch_cmd.req;
  endproperty
  a_switch_done: assert property (p_switch_done) else $error("switch completion wrong");

  property p_no_switch_mode;
    (switching_mode_setting[1] && state_q == osc_ctrl_pkg::SW_IDLE) |=> !switch_cmd.req;
  endproperty
  a_no_switch_mode: assert property (p_no_switch_mode) else $error("switch in disabled mode");

  property p_freeze;
    (frozen && state_q == osc_ctrl_pkg::SW_IDLE) |=> !switch_cmd.req && $stable(cur_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("switch while frozen");

  property p_fail_set;
    (clock_fail_detect && monitor_on) |=> fail_q ##1 (fail_q || $past(ctrl_ok));
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("fail flag not sticky");

  property p_pinmap;
    ctrl_ok |=> pin_select_wr_accept == (pin_select_wr_req && !$past(wd[`OSC_PINMAP_BIT]));
  endproperty
  a_pinmap: assert property (p_pinmap) else $error("pin select write leaked");

  property p_recover;
    (irq_event && roi_q && !wr_div) |=> !slowdown_enable_q && doze_divide == 8'h01;
  endproperty
  a_recover: assert property (p_recover) else $error("interrupt did not recover");

  property p_lock_bit;
    bus_req.rd && bus_req.addr == `OSC_IDX_CTRL && !pll_in_use |=> !rdata[`OSC_PLLLOCK_BIT];
  endproperty
  a_lock_bit: assert property (p_lock_bit) else $error("lock bit with PLL off");

  property p_read_zero;
    !bus_req.rd |=> rdata == 16'h0000;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("read data outside slot");

  property p_unmapped;
    (bus_req.rd && bus_req.addr > `OSC_IDX_TUN) |=> rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped index read nonzero");

  property p_cur_hold;
    (state_q != osc_ctrl_pkg::SW_BOOT && !(switch_cmd.req && switch_done)) |=> $stable(current_source);
  endproperty
  a_cur_hold: assert property (p_cur_hold) else $error("current source moved without switch");

  property p_unlock_used;
    (bus_req.wr && unlocked_q) |=> !unlocked_q;
  endproperty
  a_unlock_used: assert property (p_unlock_used) else $error("unlock not consumed");

  property p_secen_load;
    ctrl_ok |=> secondary_osc_en == $past(wd[`OSC_SECEN_BIT]);
  endproperty
  a_secen_load: assert property (p_secen_load) else $error("secondary enable not loaded");

  property p_fail_mode;
    (clock_fail_detect && !monitor_on && !fail_q) |=> !fail_q;
  endproperty
  a_fail_mode: assert property (p_fail_mode) else $error("fail flag set with monitor off");

  property p_doze_ratio;
    (wr_div && wd[`DIV_SLOWDOWN_ENABLE_BIT] && !irq_event) |=> doze_divide == (8'h01 << $past(wd[`DIV_DOZE_LSB +: 3]));
  endproperty
  a_doze_ratio: assert property (p_doze_ratio) else $error("slowdown ratio wrong");

  property p_frc_top;
    (wr_div && wd[`DIV_FRC_LSB +: 3] == 3'h7) |=> fast_rc_divide == 9'h100;
  endproperty
  a_frc_top: assert property (p_frc_top) else $error("postscaler top code wrong");

  property p_post_reserved;
    (wr_div && wd[`DIV_POST_LSB +: 2] == `POST_RESERVED) |=> $stable(post_q);
  endproperty
  a_post_reserved: assert property (p_post_reserved) else $error("reserved divider code taken");

  property p_pre_code;
    wr_div |=> pll_pre_divide == {1'b0, $past(wd[`DIV_PRE_LSB +: 5])} + 6'h02;
  endproperty
  a_pre_code: assert property (p_pre_code) else $error("prescaler ratio wrong");

  property p_mult_code;
    wr_fbd |=> pll_multiplier == {1'b0, $past(wd[FBD_W-1:0])} + 10'h002;
  endproperty
  a_mult_code: assert property (p_mult_code) else $error("multiplier wrong");

  property p_trim_load;
    wr_tun |=> fast_rc_trim == $past(wd[TUN_W-1:0]);
  endproperty
  a_trim_load: assert property (p_trim_load) else $error("trim not loaded");

endmodule : osc_ctrl_regs

`default_nettype wire

//--- osc_ctrl_regs_tb_top.sv
// directed bench of the oscillator control register block
// assumes the map header and package are compiled before this file
`timescale 1ns/1ns
`default_nettype none
`include "osc_ctrl_map.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module osc_ctrl_regs_tb_top;
  logic                     ref_clk = 1'b0;
  logic                     rst = 1'b1;
  osc_ctrl_pkg::reg_req_s   bus_req = '0;
  logic [15:0]              rdata;
  logic [2:0]               initial_source_setting = 3'h1;
  logic [1:0]               switching_mode_setting = 2'h0;
  osc_ctrl_pkg::switch_cmd_s switch_cmd;
  logic                     switch_done = 1'b0;
  logic                     pll_lock_in = 1'b1;
  logic                     clock_fail_detect = 1'b0;
  logic                     irq_event = 1'b0;
  logic                     pin_select_wr_req = 1'b1;
  logic                     pin_select_wr_accept;
  logic                     secondary_osc_en;
  logic [2:0]               current_source;
  logic [7:0]               doze_divide;
  logic [8:0]               fast_rc_divide;
  logic [3:0]               pll_post_divide;
  logic [5:0]               pll_pre_divide;
  logic [9:0]               pll_multiplier;
  logic [5:0]               fast_rc_trim;
  int                       n_mismatch = 0;
  int                       cmp_count = 0;

  always #2 ref_clk = ~ref_clk;

  osc_ctrl_regs i_osc_ctrl_regs (.ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
    .initial_source_setting(initial_source_setting), .switching_mode_setting(switching_mode_setting),
    .switch_cmd(switch_cmd), .switch_done(switch_done), .pll_lock_in(pll_lock_in),
    .clock_fail_detect(clock_fail_detect), .irq_event(irq_event), .pin_select_wr_req(pin_select_wr_req),
    .pin_select_wr_accept(pin_select_wr_accept), .secondary_osc_en(secondary_osc_en),
    .current_source(current_source), .doze_divide(doze_divide), .fast_rc_divide(fast_rc_divide),
    .pll_post_divide(pll_post_divide), .pll_pre_divide(pll_pre_divide),
    .pll_multiplier(pll_multiplier), .fast_rc_trim(fast_rc_trim));

  task automatic results();
    $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  task automatic por(input logic [1:0] mode, input logic [2:0] src);
    @(posedge ref_clk);
    rst <= 1'b1;
    switching_mode_setting <= mode;
    initial_source_setting <= src;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : por

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask : wr

  // unlock pair then control write, back to back
  task automatic uwr(input logic [15:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: `OSC_IDX_UNLOCK, wdata: `UNLOCK_KEY1, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req <= '{addr: `OSC_IDX_UNLOCK, wdata: `UNLOCK_KEY2, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req <= '{addr: `OSC_IDX_CTRL, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req <= '0;
  endtask : uwr

  task automatic rd(input logic [2:0] a, input logic [15:0] e, input string nm);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req <= '0;
    #1;
    `CHK(nm, e, rdata)
  endtask : rd

  task automatic pulse_irq();
    @(posedge ref_clk);
    irq_event <= 1'b1;
    @(posedge ref_clk);
    irq_event <= 1'b0;
    @(posedge ref_clk);
  endtask : pulse_irq

  initial begin
    logic [2:0] k;
    int         w;
    por(2'h0, 3'h1);
    rd(`OSC_IDX_CTRL, 16'h1120, "ctrl reset");
    rd(`OSC_IDX_DIV, 16'h3040, "div reset");
    rd(`OSC_IDX_FBD, 16'h0030, "fbd reset");
    rd(`OSC_IDX_TUN, 16'h0000, "tun reset");
    `CHK("mult reset", 10'h032, pll_multiplier)
    `CHK("post reset", 4'h4, pll_post_divide)
    `CHK("pre reset", 6'h02, pll_pre_divide)
    `CHK("frc reset", 9'h001, fast_rc_divide)
    rd(3'h5, 16'h0000, "unmapped");
    rd(`OSC_IDX_UNLOCK, 16'h0000, "unlock index");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      wr(`OSC_IDX_DIV, {1'b0, k, 1'b1, k, 5'h00, k});
      #1;
      `CHK("doze", 8'(1 << i), doze_divide)
      `CHK("frc", (i == 7) ? 9'h100 : 9'(1 << i), fast_rc_divide)
      `CHK("pre", 6'(i + 2), pll_pre_divide)
    end
    wr(`OSC_IDX_DIV, 16'h00DF);
    #1;
    `CHK("doze off", 8'h01, doze_divide)
    `CHK("pre max", 6'h21, pll_pre_divide)
    `CHK("post 8", 4'h8, pll_post_divide)
    wr(`OSC_IDX_DIV, 16'h0080);
    rd(`OSC_IDX_DIV, 16'h00C0, "post reserved");
    wr(`OSC_IDX_DIV, 16'h0000);
    #1;
    `CHK("post 2", 4'h2, pll_post_divide)
    wr(`OSC_IDX_DIV, 16'hFFFF);
    rd(`OSC_IDX_DIV, 16'hFFDF, "div unimpl");
    wr(`OSC_IDX_DIV, 16'hB800);
    pulse_irq();
    rd(`OSC_IDX_DIV, 16'hB000, "roi clears");
    `CHK("doze 1:1", 8'h01, doze_divide)
    wr(`OSC_IDX_DIV, 16'h3800);
    pulse_irq();
    rd(`OSC_IDX_DIV, 16'h3800, "roi off");
    wr(`OSC_IDX_FBD, 16'hFFFF);
    rd(`OSC_IDX_FBD, 16'h01FF, "fbd max");
    `CHK("mult max", 10'h201, pll_multiplier)
    wr(`OSC_IDX_TUN, 16'hFFDF);
    rd(`OSC_IDX_TUN, 16'h001F, "tun top");
    `CHK("trim", 6'h1F, fast_rc_trim)
    $display("test dividers done");
    @(posedge ref_clk);
    clock_fail_detect <= 1'b1;
    @(posedge ref_clk);
    clock_fail_detect <= 1'b0;
    wr(`OSC_IDX_CTRL, 16'h0142);
    rd(`OSC_IDX_CTRL, 16'h1128, "locked write");
    rd(`OSC_IDX_CTRL, 16'h1128, "fail sticky");
    uwr(16'h0142);
    rd(`OSC_IDX_CTRL, 16'h1162, "ctrl write");
    `CHK("sec en", 1'b1, secondary_osc_en)
    `CHK("pps frozen", 1'b0, pin_select_wr_accept)
    uwr(16'h0100);
    #1;
    `CHK("sec off", 1'b0, secondary_osc_en)
    `CHK("pps open", 1'b1, pin_select_wr_accept)
    uwr(16'h0301);
    w = 0;
    while (switch_cmd.req !== 1'b1 && w < 20) begin
      @(posedge ref_clk);
      w++;
    end
    if (w >= 20) begin
      n_mismatch++;
      results();
    end
    `CHK("target", 3'h3, switch_cmd.target)
    repeat (3) @(posedge ref_clk);
    switch_done <= 1'b1;
    @(posedge ref_clk);
    switch_done <= 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK("req done", 1'b0, switch_cmd.req)
    `CHK("cur", 3'h3, current_source)
    rd(`OSC_IDX_CTRL, 16'h3320, "switched");
    @(posedge ref_clk);
    pll_lock_in <= 1'b0;
    rd(`OSC_IDX_CTRL, 16'h3300, "unlocked pll");
    @(posedge ref_clk);
    pll_lock_in <= 1'b1;
    $display("test switch done");
    por(2'h1, 3'h0);
    rd(`OSC_IDX_DIV, 16'h3040, "por div");
    `CHK("por trim", 6'h00, fast_rc_trim)
    @(posedge ref_clk);
    clock_fail_detect <= 1'b1;
    uwr(16'h0180);
    uwr(16'h0181);
    clock_fail_detect <= 1'b0;
    repeat (4) @(posedge ref_clk);
    `CHK("freeze req", 1'b0, switch_cmd.req)
    rd(`OSC_IDX_CTRL, 16'h0180, "freeze");
    uwr(16'h0100);
    uwr(16'h0101);
    #1;
    `CHK("unfrozen req", 1'b1, switch_cmd.req)
    por(2'h2, 3'h7);
    rd(`OSC_IDX_CTRL, 16'h7700, "strap 7");
    uwr(16'h0001);
    repeat (4) @(posedge ref_clk);
    `CHK("mode off req", 1'b0, switch_cmd.req)
    `CHK("mode off cur", 3'h7, current_source)
    $display("test modes done");
    results();
  end
endmodule : osc_ctrl_regs_tb_top
`default_nettype wire
